/* File: src/smg_pkg.sv */
// Constants shared by the serial module global control block
package smg_pkg;

  localparam int DW = 16;
  localparam int AW = 3;

  // Word addresses of the register port
  localparam logic [2:0] ADDR_CFG = 3'h0;
  localparam logic [2:0] ADDR_INT = 3'h1;
  localparam logic [2:0] ADDR_PIN = 3'h2;
  localparam logic [2:0] ADDR_DAT = 3'h3;

  // module_config_register fields
  localparam int CFG_STOP = 15;
  localparam int CFG_FREEZE_HALT_ENABLE = 14;
  localparam int CFG_FREEZE_UNUSED_BIT = 13;
  localparam int CFG_ARB_LSB = 0;
  localparam int ARB_W = 4;
  localparam logic [15:0] CFG_RST = 16'h8000;

  // interrupt_level_select (high byte) and interrupt_vector_number (low byte)
  localparam int LVL_W = 3;
  localparam int LVL_Q_LSB = 11;
  localparam int LVL_A_LSB = 8;
  localparam int VEC_LSB = 1;
  localparam logic [2:0] LVL_RST = 3'h0;
  localparam logic [7:0] VEC_RST = 8'h0F;

  // port_pin_assignment (high byte), port_pin_direction (low byte)
  localparam int PAR_LSB = 8;
  localparam int DDR_LSB = 0;
  localparam logic [7:0] PIN_RST = 8'h00;
  localparam logic [7:0] DAT_RST = 8'h00;

  // Pin positions
  localparam int PIN_MISO = 0;
  localparam int PIN_MOSI = 1;
  localparam int PIN_SCK = 2;
  localparam int PIN_SS = 3;
  localparam int PIN_PCS1 = 4;
  localparam int PIN_TXD = 7;
  localparam int NPIN = 8;

  typedef enum logic [1:0] {
    SMG_IDLE = 2'b00,
    SMG_ARB = 2'b01,
    SMG_VEC = 2'b10
  } smg_ack_state_t;

endpackage

/* File: src/smg_top.sv */
// Global control, interrupt arbitration and pin control of the dual serial module
`timescale 1ns/1ps

module smg_top
  import smg_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  // Register port
  input wire logic [AW-1:0] addr_i,
  input wire logic [DW-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [DW-1:0] rdata_o,
  // Module clock gate and freeze
  output logic module_clk_en_o,
  input wire logic freeze_i,
  input wire logic boundary_i,
  output logic freeze_halt_o,
  // Interrupt requests and acknowledge
  input wire logic queued_irq_i,
  input wire logic async_irq_i,
  output logic [6:0] irq_o,
  input wire logic iack_i,
  input wire logic [2:0] priority_mask_i,
  input wire logic arb_i,
  output logic arb_o,
  output logic arb_oe_o,
  output logic [7:0] vec_o,
  output logic vec_valid_o,
  // Serial engine side
  input wire logic queued_interface_enable_i,
  input wire logic master_i,
  input wire logic transmitter_enable_bit_i,
  input wire logic miso_out_i,
  input wire logic mosi_out_i,
  input wire logic sck_out_i,
  input wire logic [3:0] pcs_out_i,
  input wire logic txd_i,
  output logic miso_in_o,
  output logic mosi_in_o,
  output logic sck_in_o,
  output logic ss_in_n_o,
  output logic mode_fault_o,
  // Port pins
  input wire logic [NPIN-1:0] pin_i,
  output logic [NPIN-1:0] pin_o,
  output logic [NPIN-1:0] pin_oe_o
);

  logic stop;
  logic freeze_halt_enable;
  logic freeze_unused_bit;
  logic [ARB_W-1:0] arb_num;
  logic [LVL_W-1:0] lvl_q;
  logic [LVL_W-1:0] lvl_a;
  logic [7:1] vec_hi;
  logic [7:0] pin_assign;
  logic [7:0] pin_dir;
  logic [7:0] pin_data;
  logic [NPIN-1:0] pin_meta;
  logic [NPIN-1:0] pin_sync;
  logic [DW-1:0] next_rdata;
  smg_ack_state_t state;
  logic [1:0] bit_idx;
  logic in_race;
  logic src_queued;
  logic elig_q;
  logic elig_a;
  logic my_bit;
  logic lose_bit;
  logic race_won;
  logic accept;
  logic pick_q;
  logic [7:0] q_oe;
  logic [7:0] q_out;
  logic [7:0] own;
  logic [6:0] next_irq;

  // Register writes; allowed while stopped
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      stop <= CFG_RST[CFG_STOP];
    end else if (wr_i && addr_i == ADDR_CFG) begin
      stop <= wdata_i[CFG_STOP];
    end
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      freeze_halt_enable <= CFG_RST[CFG_FREEZE_HALT_ENABLE];
      freeze_unused_bit <= CFG_RST[CFG_FREEZE_UNUSED_BIT];
    end else if (wr_i && addr_i == ADDR_CFG) begin
      freeze_halt_enable <= wdata_i[CFG_FREEZE_HALT_ENABLE];
      freeze_unused_bit <= wdata_i[CFG_FREEZE_UNUSED_BIT];
    end
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      arb_num <= CFG_RST[CFG_ARB_LSB +: ARB_W];
    end else if (wr_i && addr_i == ADDR_CFG) begin
      arb_num <= wdata_i[CFG_ARB_LSB +: ARB_W];
    end
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      lvl_q <= LVL_RST;
    end else if (wr_i && addr_i == ADDR_INT) begin
      lvl_q <= wdata_i[LVL_Q_LSB +: LVL_W];
    end
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      lvl_a <= LVL_RST;
    end else if (wr_i && addr_i == ADDR_INT) begin
      lvl_a <= wdata_i[LVL_A_LSB +: LVL_W];
    end
  end

  // Bit zero is never stored; the winning source fills it in
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      vec_hi <= VEC_RST[7:1];
    end else if (wr_i && addr_i == ADDR_INT) begin
      vec_hi <= wdata_i[VEC_LSB +: 7];
    end
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pin_assign <= PIN_RST;
    end else if (wr_i && addr_i == ADDR_PIN) begin
      pin_assign <= wdata_i[PAR_LSB +: 8];
    end
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pin_dir <= PIN_RST;
    end else if (wr_i && addr_i == ADDR_PIN) begin
      pin_dir <= wdata_i[DDR_LSB +: 8];
    end
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pin_data <= DAT_RST;
    end else if (wr_i && addr_i == ADDR_DAT) begin
      pin_data <= wdata_i[7:0];
    end
  end

  // Pins come from outside; two flops before use
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pin_meta <= '0;
      pin_sync <= '0;
    end else begin
      pin_meta <= pin_i;
      pin_sync <= pin_meta;
    end
  end

  // Read data; while stopped only the config word is returned
  always_comb begin
    next_rdata = '0;
    unique case (addr_i)
      ADDR_CFG: begin
        next_rdata[CFG_STOP] = stop;
        next_rdata[CFG_FREEZE_HALT_ENABLE] = freeze_halt_enable;
        next_rdata[CFG_FREEZE_UNUSED_BIT] = freeze_unused_bit;
        next_rdata[CFG_ARB_LSB +: ARB_W] = arb_num;
      end
      ADDR_INT: begin
        next_rdata[LVL_Q_LSB +: LVL_W] = lvl_q;
        next_rdata[LVL_A_LSB +: LVL_W] = lvl_a;
        next_rdata[VEC_LSB +: 7] = vec_hi;
        next_rdata[0] = 1'b1;
      end
      ADDR_PIN: begin
        next_rdata[PAR_LSB +: 8] = pin_assign;
        next_rdata[DDR_LSB +: 8] = pin_dir;
      end
      ADDR_DAT: begin
        next_rdata[7:0] = pin_sync;
      end
      default: begin
        next_rdata = '0;
      end
    endcase
    if (stop && addr_i != ADDR_CFG) begin
      next_rdata = '0;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rdata_o <= '0;
    end else if (rd_i) begin
      rdata_o <= next_rdata;
    end else begin
      rdata_o <= '0;
    end
  end

  // The serial engines run only while not stopped
  assign module_clk_en_o = !stop;

  // Lower freeze bit is kept for read-back and has no action
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      freeze_halt_o <= 1'b0;
    end else if (!freeze_i) begin
      freeze_halt_o <= 1'b0;
    end else if (freeze_halt_enable && boundary_i) begin
      freeze_halt_o <= 1'b1;
    end
  end

  // Request lines; level zero silences an interface
  always_comb begin
    next_irq = '0;
    if (async_irq_i && lvl_a != 3'h0) begin
      next_irq[lvl_a - 3'h1] = 1'b1;
    end
    if (queued_irq_i && lvl_q != 3'h0) begin
      next_irq[lvl_q - 3'h1] = 1'b1;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      irq_o <= '0;
    end else begin
      irq_o <= next_irq;
    end
  end

  // Only requests above the acknowledged mask may contend
  assign elig_q = queued_irq_i && lvl_q != 3'h0 && lvl_q > priority_mask_i;
  assign elig_a = async_irq_i && lvl_a != 3'h0 && lvl_a > priority_mask_i;
  // Source is fixed at acknowledge so a late request cannot swap the vector
  assign accept = iack_i && arb_num != 4'h0 && (elig_q || elig_a);
  assign pick_q = elig_q && (!elig_a || lvl_q >= lvl_a);
  // Our bit is zero while a rival drives one: drop out
  assign lose_bit = in_race && !my_bit && arb_i;
  assign race_won = state == SMG_ARB && bit_idx == 2'h0 && in_race && !lose_bit;

  assign my_bit = arb_num[bit_idx];
  assign arb_o = my_bit;
  // Wired line: a module drives only its one bits
  assign arb_oe_o = state == SMG_ARB && in_race && my_bit;

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state <= SMG_IDLE;
      bit_idx <= 2'h3;
      in_race <= 1'b0;
      src_queued <= 1'b0;
    end else begin
      unique case (state)
        SMG_IDLE: begin
          bit_idx <= 2'h3;
          // A zero arbitration number keeps the module out
          if (accept) begin
            state <= SMG_ARB;
            in_race <= 1'b1;
            src_queued <= pick_q;
          end
        end
        SMG_ARB: begin
          if (lose_bit) begin
            in_race <= 1'b0;
          end
          if (bit_idx == 2'h0) begin
            state <= (in_race && !lose_bit) ? SMG_VEC : SMG_IDLE;
          end else begin
            bit_idx <= bit_idx - 2'h1;
          end
        end
        SMG_VEC: begin
          state <= SMG_IDLE;
          in_race <= 1'b0;
        end
        default: begin
          state <= SMG_IDLE;
        end
      endcase
    end
  end

  // Vector answer for one cycle after a won race
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      vec_o <= 8'h00;
    end else if (race_won) begin
      vec_o <= {vec_hi, src_queued};
    end else begin
      vec_o <= 8'h00;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      vec_valid_o <= 1'b0;
    end else begin
      vec_valid_o <= race_won;
    end
  end

  // Queued interface owns a pin only when assigned and enabled
  assign own = pin_assign & {8{queued_interface_enable_i}};

  always_comb begin
    q_oe = '0;
    q_out = '0;
    q_oe[PIN_MISO] = !master_i && pin_dir[PIN_MISO];
    q_out[PIN_MISO] = miso_out_i;
    q_oe[PIN_MOSI] = master_i && pin_dir[PIN_MOSI];
    q_out[PIN_MOSI] = mosi_out_i;
    q_oe[PIN_SCK] = master_i;
    q_out[PIN_SCK] = sck_out_i;
    q_oe[PIN_SS] = master_i && pin_dir[PIN_SS];
    q_out[PIN_SS] = pcs_out_i[0];
    for (int k = 0; k < 3; k++) begin
      q_oe[PIN_PCS1 + k] = master_i && pin_dir[PIN_PCS1 + k];
      q_out[PIN_PCS1 + k] = pcs_out_i[k + 1];
    end
  end

  // Per pin: queued use, transmit override or general I/O
  for (genvar g = 0; g < NPIN; g++) begin : g_pin
    if (g == PIN_TXD) begin : g_txd
      // Assignment does not touch the transmit pin
      assign pin_oe_o[g] = transmitter_enable_bit_i || pin_dir[g];
      assign pin_o[g] = transmitter_enable_bit_i ? txd_i : pin_data[g];
    end else begin : g_gen
      assign pin_oe_o[g] = own[g] ? q_oe[g] : pin_dir[g];
      assign pin_o[g] = own[g] ? q_out[g] : pin_data[g];
    end
  end

  // Disabled inputs present an idle level to the engine
  assign miso_in_o = own[PIN_MISO] && master_i && !pin_dir[PIN_MISO] && pin_sync[PIN_MISO];
  assign mosi_in_o = own[PIN_MOSI] && !master_i && !pin_dir[PIN_MOSI] && pin_sync[PIN_MOSI];
  assign sck_in_o = own[PIN_SCK] && !master_i && pin_sync[PIN_SCK];
  assign ss_in_n_o = !(own[PIN_SS] && !master_i && !pin_dir[PIN_SS] && !pin_sync[PIN_SS]);
  assign mode_fault_o = own[PIN_SS] && master_i && !pin_dir[PIN_SS] && !pin_sync[PIN_SS];

endmodule

/* File: testbench/smg_host.sv */
// Host model: acknowledge cycles and one rival module on the arbitration line
`timescale 1ns/1ps
module smg_host (
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  input wire logic go_i,
  input wire logic [2:0] mask_i,
  input wire logic [3:0] rival_i,
  input wire logic arb_o,
  input wire logic arb_oe_o,
  output logic iack_o,
  output logic [2:0] priority_mask_o,
  output logic arb_line_o
);
  logic [2:0] cnt;
  logic lost;
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      iack_o <= 1'b0;
      priority_mask_o <= 3'h0;
      cnt <= 3'h0;
      lost <= 1'b0;
    end else begin
      iack_o <= go_i;
      // Mask bus carries junk outside the acknowledge cycle
      priority_mask_o <= go_i ? mask_i : ~priority_mask_o;
      if (iack_o) begin
        cnt <= 3'h4;
        lost <= (rival_i == 4'h0);
      end else if (cnt != 3'h0) begin
        cnt <= cnt - 3'h1;
        if (!rival_i[cnt - 3'h1] && arb_line_o) lost <= 1'b1;
      end
    end
  end
  // Wired line: high if any contender drives a one
  assign arb_line_o = (arb_oe_o & arb_o) | ((cnt != 3'h0) && !lost && rival_i[cnt - 3'h1]);
endmodule

/* File: testbench/smg_chk.sv */
// Assertion checker for the serial module global control block
`timescale 1ns/1ps
module smg_chk
  import smg_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  input wire logic [AW-1:0] addr_i,
  input wire logic [DW-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [DW-1:0] rdata_o,
  input wire logic module_clk_en_o,
  input wire logic freeze_i,
  input wire logic freeze_halt_o,
  input wire logic queued_irq_i,
  input wire logic async_irq_i,
  input wire logic [6:0] irq_o,
  input wire logic iack_i,
  input wire logic arb_oe_o,
  input wire logic vec_valid_o,
  input wire logic transmitter_enable_bit_i,
  input wire logic txd_i,
  input wire logic [NPIN-1:0] pin_o,
  input wire logic [NPIN-1:0] pin_oe_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rstn_i);
  sequence s_ack_win;
    iack_i ##5 vec_valid_o;
  endsequence
  a_stop_gate: assert property (wr_i && addr_i == ADDR_CFG |=> module_clk_en_o == !$past(wdata_i[CFG_STOP]))
    else $error("clock enable does not follow stop bit");
  a_stopped_read: assert property (rd_i && addr_i != ADDR_CFG && !module_clk_en_o |=> rdata_o == 16'h0000)
    else $error("register readable while stopped");
  a_vec_bit_one: assert property (rd_i && addr_i == ADDR_INT && module_clk_en_o |=> rdata_o[0] && !rdata_o[15])
    else $error("vector bit zero does not read one");
  a_cfg_unused: assert property (rd_i && addr_i == ADDR_CFG |=> rdata_o[12:4] == 9'h000)
    else $error("unimplemented config bits read nonzero");
  a_vec_timing: assert property (vec_valid_o |-> $past(iack_i, 5))
    else $error("vector without acknowledge five cycles before");
  a_arb_driven: assert property (vec_valid_o |-> $past(arb_oe_o, 1) || $past(arb_oe_o, 2)
    || $past(arb_oe_o, 3) || $past(arb_oe_o, 4)) else $error("vector without arbitration contention");
  a_irq_quiet: assert property (!queued_irq_i && !async_irq_i |=> irq_o == 7'h00)
    else $error("request line without request");
  a_txd_force: assert property (transmitter_enable_bit_i |-> pin_oe_o[PIN_TXD] && pin_o[PIN_TXD] == txd_i)
    else $error("transmit pin not forced to output");
  a_freeze_drop: assert property (!freeze_i |=> !freeze_halt_o)
    else $error("halt held without freeze");
  c_ack_win: cover property (s_ack_win);
endmodule

/* File: testbench/smg_tb_top.sv */
// Self-checking bench for the serial module global control block
`timescale 1ns/1ps
module smg_tb_top
  import smg_pkg::*;
;
  logic ref_clk_i, rstn_i = 0, wr_i = 0, rd_i = 0, freeze_i = 0, boundary_i = 0, queued_irq_i = 0, async_irq_i = 0;
  logic queued_interface_enable_i = 0, master_i = 0, transmitter_enable_bit_i = 0, go = 0, rd_d = 0;
  logic miso_out_i = 0, mosi_out_i = 0, sck_out_i = 0, txd_i = 0, iack_i, arb_i, arb_o, arb_oe_o, vec_valid_o;
  logic module_clk_en_o, freeze_halt_o, miso_in_o, mosi_in_o, sck_in_o, ss_in_n_o, mode_fault_o;
  logic [AW-1:0] addr_i = 0;
  logic [DW-1:0] wdata_i = 0, rdata_o, rq[$];
  logic [2:0] priority_mask_i, mask = 0;
  logic [3:0] pcs_out_i = 0, rival = 0;
  logic [6:0] irq_o;
  logic [7:0] vec_o, pin_o, pin_oe_o, pin_i = 0, e, vq[$];
  logic [31:0] seed;
  int bad_count = 0, total_checks = 0;
  smg_top uut (.*);
  smg_host host (.ref_clk_i, .rstn_i, .go_i(go), .mask_i(mask), .rival_i(rival), .arb_o, .arb_oe_o,
    .iack_o(iack_i), .priority_mask_o(priority_mask_i), .arb_line_o(arb_i));
  initial begin
    ref_clk_i = 0;
    forever #4 ref_clk_i = ~ref_clk_i;
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  task automatic chk(input string n, input logic [15:0] x, input logic [15:0] g);
    total_checks++;
    if (g !== x) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, x, g);
    end
  endtask
  task automatic complete_run;
    if (bad_count == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    @(posedge ref_clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge ref_clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a, input logic [15:0] x);
    rq.push_back(x);
    @(posedge ref_clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge ref_clk_i);
    rd_i <= 1'b0;
  endtask
  task automatic ack(input logic [2:0] m, input logic [3:0] r, input logic win, input logic [7:0] v);
    if (win) vq.push_back(v);
    @(posedge ref_clk_i);
    go <= 1'b1;
    mask <= m;
    rival <= r;
    @(posedge ref_clk_i);
    go <= 1'b0;
    repeat (9) @(posedge ref_clk_i);
  endtask
  task automatic frz(input logic x);
    freeze_i <= 1'b1;
    @(posedge ref_clk_i);
    boundary_i <= 1'b1;
    @(posedge ref_clk_i);
    boundary_i <= 1'b0;
    @(negedge ref_clk_i);
    chk("freeze halt", x, freeze_halt_o);
    @(posedge ref_clk_i);
    freeze_i <= 1'b0;
  endtask
  always @(posedge ref_clk_i) rd_d <= rd_i;
  // Results are taken off the queues where they appear, mid-cycle
  always @(negedge ref_clk_i) begin
    if (rd_d) chk("read data", rq.pop_front(), rdata_o);
    if (vec_valid_o === 1'b1 && vq.size() == 0) chk("unexpected vector", 16'h0000, 16'h0001);
    else if (vec_valid_o === 1'b1) chk("vector", vq.pop_front(), vec_o);
  end
  initial begin
    repeat (20000) @(posedge ref_clk_i);
    chk("timeout", 16'h0000, 16'h0001);
    complete_run();
  end
  initial begin
    seed = 33;
    repeat (3) @(posedge ref_clk_i);
    rstn_i <= 1'b1;
    rd(ADDR_CFG, CFG_RST);
    rd(ADDR_INT, 16'h0000);
    chk("clock enable", 16'h0000, module_clk_en_o);
    wr(ADDR_CFG, 16'h5FF5);
    rd(ADDR_CFG, 16'h4005);
    rd(ADDR_INT, {8'h00, VEC_RST});
    rd(3'h5, 16'h0000);
    wr(ADDR_CFG, 16'h8005);
    wr(ADDR_INT, 16'hFF54);
    wr(3'h5, 16'hFFFF);
    wr(ADDR_CFG, 16'h4005);
    rd(ADDR_INT, 16'h3F55);
    for (int l = 0; l < 8; l++) begin
      seed = xs(seed);
      wr(ADDR_INT, {2'b00, 3'(l), 3'(7 - l), 8'h54});
      queued_irq_i <= seed[0];
      async_irq_i <= seed[1];
      repeat (3) @(negedge ref_clk_i);
      e = ({7'h00, seed[0]} << l) | ({7'h00, seed[1]} << (7 - l));
      chk("request lines", e[7:1], irq_o);
    end
    wr(ADDR_INT, 16'h1B54);
    queued_irq_i <= 1'b1;
    async_irq_i <= 1'b1;
    ack(3'h2, 4'h3, 1'b1, 8'h55);
    ack(3'h2, 4'h6, 1'b0, 8'h00);
    ack(3'h3, 4'h0, 1'b0, 8'h00);
    wr(ADDR_INT, 16'h1554);
    ack(3'h4, 4'h0, 1'b1, 8'h54);
    queued_irq_i <= 1'b0;
    async_irq_i <= 1'b0;
    frz(1'b1);
    wr(ADDR_CFG, 16'h2005);
    frz(1'b0);
    seed = xs(seed);
    {miso_out_i, mosi_out_i, sck_out_i, pcs_out_i, txd_i} <= seed[15:8];
    pin_i <= seed[23:16];
    wr(ADDR_DAT, 16'h00A5);
    wr(ADDR_PIN, 16'h00FF);
    repeat (3) @(negedge ref_clk_i);
    chk("gpio drive", 16'hFFA5, {pin_oe_o, pin_o});
    rd(ADDR_DAT, {8'h00, pin_i});
    wr(ADDR_PIN, 16'hFF00);
    repeat (2) @(negedge ref_clk_i);
    chk("gpio inputs", 16'h0000, pin_oe_o);
    @(posedge ref_clk_i);
    queued_interface_enable_i <= 1'b1;
    master_i <= 1'b1;
    transmitter_enable_bit_i <= 1'b1;
    wr(ADDR_PIN, 16'hFF0E);
    repeat (2) @(negedge ref_clk_i);
    chk("master pins", {8'h8E, txd_i, 3'h0, pcs_out_i[0], sck_out_i, mosi_out_i, 1'b0},
      {pin_oe_o, pin_o & pin_oe_o});
    chk("master inputs", {pin_i[0], 4'h1}, {miso_in_o, mosi_in_o, sck_in_o, mode_fault_o, ss_in_n_o});
    @(posedge ref_clk_i);
    master_i <= 1'b0;
    wr(ADDR_PIN, 16'hFF01);
    repeat (2) @(negedge ref_clk_i);
    chk("slave pins", {8'h81, txd_i, 6'h00, miso_out_i}, {pin_oe_o, pin_o & pin_oe_o});
    chk("slave inputs", {pin_i[3], pin_i[1], pin_i[2], 2'b00},
      {ss_in_n_o, mosi_in_o, sck_in_o, miso_in_o, mode_fault_o});
    @(posedge ref_clk_i);
    master_i <= 1'b1;
    pin_i[3] <= 1'b0;
    repeat (3) @(negedge ref_clk_i);
    chk("mode fault", {1'b1, 1'b0, 1'b1}, {mode_fault_o, miso_in_o, ss_in_n_o});
    @(posedge ref_clk_i);
    rstn_i <= 1'b0;
    repeat (2) @(posedge ref_clk_i);
    rstn_i <= 1'b1;
    rd(ADDR_CFG, CFG_RST);
    chk("clock enable after reset", 16'h0000, module_clk_en_o);
    repeat (3) @(posedge ref_clk_i);
    chk("pending results", 16'h0000, 16'(rq.size() + vq.size()));
    complete_run();
  end
endmodule
bind smg_top smg_chk chk (.*);
